// file: fml_pkg.sv
// shared constants and carrier types for the fault interrupt mask and latch block
package fml_pkg;

  // register access widths
  localparam int FML_ADDR_W = 8;
  localparam int FML_DATA_W = 8;

  // register byte offsets on the control port
  localparam logic [7:0] FML_OFS_DEV_MASK = 8'h29;
  localparam logic [7:0] FML_OFS_CH_MASK = 8'h2a;
  localparam logic [7:0] FML_OFS_DIAG_MASK = 8'h2b;
  localparam logic [7:0] FML_OFS_LATCH = 8'h2c;

  // reset values
  localparam logic [7:0] FML_RST_DEV_MASK = 8'hff;
  localparam logic [7:0] FML_RST_CH_MASK = 8'h03;
  localparam logic [7:0] FML_RST_DIAG_MASK = 8'h00;
  localparam logic [3:0] FML_RST_LATCH = 4'h0;
  localparam logic [7:0] FML_RDATA_IDLE = 8'h00;
  localparam logic [3:0] FML_RESERVED_ZERO = 4'h0;
  // irq pin level while reset holds: inactive for the default active-low polarity
  localparam logic FML_IRQ_RST_LEVEL = 1'b1;

  // device event field: register bits 7..4, index 3..0 inside the field
  localparam int FML_EVT_N = 4;
  localparam int FML_EVT_LSB = 4;
  localparam int FML_EVT_MSB = 7;
  localparam int FML_EVT_ASI = 3;
  localparam int FML_EVT_PLL = 2;
  localparam int FML_EVT_OTEMP = 1;
  localparam int FML_EVT_OCURR = 0;

  // channel summary mask bits
  localparam int FML_BIT_CH1 = 7;
  localparam int FML_BIT_CH2 = 6;

  // diagnostic fault type bits, same layout in mask and channel latches
  localparam int FML_DIAG_OPEN = 7;
  localparam int FML_DIAG_PAIR = 6;
  localparam int FML_DIAG_GND_P = 5;
  localparam int FML_DIAG_GND_N = 4;
  localparam int FML_DIAG_BIAS_P = 3;
  localparam int FML_DIAG_BIAS_N = 2;
  localparam int FML_DIAG_BAT_P = 1;
  localparam int FML_DIAG_BAT_N = 0;

  // interrupt event mode that this block implements
  localparam logic [1:0] FML_EVENT_MODE_LEVEL = 2'h0;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [FML_ADDR_W-1:0] addr;
    logic [FML_DATA_W-1:0] wdata;
  } fml_req_t;

  typedef struct packed {
    logic asi_clock_error;
    logic pll_lock;
    logic over_temp;
    logic over_current;
  } fml_dev_evt_t;

  typedef struct packed {
    logic [FML_DATA_W-1:0] ch1;
    logic [FML_DATA_W-1:0] ch2;
  } fml_ch_faults_t;

  typedef struct packed {
    logic irq_output_polarity;
    logic [1:0] event_mode;
    logic latched_readback_option;
    logic clear_on_read_option;
  } fml_cfg_t;

endpackage

// file: fml_sync2.sv
// two flip-flop level synchroniser for live event lines
`timescale 1ns/1ps
module fml_sync2 #(
  parameter int WIDTH = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

// file: fml_irq_mask_latch.sv
// interrupt masks, latched device events and interrupt pin drive
`timescale 1ns/1ps
module fml_irq_mask_latch
  import fml_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire fml_req_t req,
  input wire fml_dev_evt_t dev_evt_live,
  input wire fml_ch_faults_t ch_faults,
  input wire fml_cfg_t cfg,
  output logic [FML_DATA_W-1:0] rdata,
  output logic rdata_valid,
  output logic irq_out
);

  // address decode shared by write and clear paths; the read mux decodes with its own case
  function automatic logic reg_hit(input logic [FML_ADDR_W-1:0] addr,
                                   input logic [FML_ADDR_W-1:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  // one channel's fault summary after per-type masking
  function automatic logic chan_summary(input logic [FML_DATA_W-1:0] faults,
                                        input logic [FML_DATA_W-1:0] type_mask);
    chan_summary = |(faults & ~type_mask);
  endfunction

  logic [FML_EVT_N-1:0] live_sync;
  logic [FML_EVT_N-1:0] live_prev_r;
  logic [FML_EVT_N-1:0] latch_r;
  logic [FML_EVT_N-1:0] latch_nxt;
  logic [FML_EVT_N-1:0] evt_rise;
  logic [FML_EVT_N-1:0] evt_set;
  logic [FML_EVT_N-1:0] dev_unmasked;
  logic [FML_EVT_N-1:0] latch_view;
  logic [FML_DATA_W-1:0] dev_mask_r;
  logic [FML_DATA_W-1:0] ch_mask_r;
  logic [FML_DATA_W-1:0] diag_mask_r;
  logic [FML_DATA_W-1:0] rdata_r;
  logic [FML_DATA_W-1:0] rd_mux;
  logic rdata_valid_r;
  logic irq_active_r;
  logic irq_out_r;
  logic irq_any;
  logic ch1_hit;
  logic ch2_hit;
  logic rd_latch;

  // event lines come from analog and clock monitors, so they cross first
  fml_sync2 #(
    .WIDTH(FML_EVT_N)
  ) u_evt_sync (
    .clk(clk),
    .rstn(rstn),
    .async_in(dev_evt_live),
    .sync_out(live_sync)
  );

  // previous synchronised level for rising-edge detection
  always_ff @(posedge clk) begin
    if (!rstn) begin
      live_prev_r <= '0;
    end else begin
      live_prev_r <= live_sync;
    end
  end

  assign rd_latch = req.rd_en & reg_hit(req.addr, FML_OFS_LATCH);
  assign evt_rise = live_sync & ~live_prev_r;

  // option 0 keeps setting while live is high, so a read cannot clear it early
  assign evt_set = cfg.clear_on_read_option ? evt_rise : live_sync;

  // set wins over the read clear; mask plays no part here
  assign latch_nxt = (latch_r & ~{FML_EVT_N{rd_latch}}) | evt_set;

  // latched device events, self-clearing on read
  always_ff @(posedge clk) begin
    if (!rstn) begin
      latch_r <= FML_RST_LATCH;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  // mask registers; reserved bits store whatever is written, host keeps them
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dev_mask_r <= FML_RST_DEV_MASK;
      ch_mask_r <= FML_RST_CH_MASK;
      diag_mask_r <= FML_RST_DIAG_MASK;
    end else if (req.wr_en) begin
      if (reg_hit(req.addr, FML_OFS_DEV_MASK)) begin
        dev_mask_r <= req.wdata;
      end
      if (reg_hit(req.addr, FML_OFS_CH_MASK)) begin
        ch_mask_r <= req.wdata;
      end
      if (reg_hit(req.addr, FML_OFS_DIAG_MASK)) begin
        diag_mask_r <= req.wdata;
      end
    end
  end

  // device events that survive their mask bit
  assign dev_unmasked = latch_r & ~dev_mask_r[FML_EVT_MSB:FML_EVT_LSB];

  // per-type masks apply to both channels alike
  assign ch1_hit = chan_summary(ch_faults.ch1, diag_mask_r) & ~ch_mask_r[FML_BIT_CH1];
  assign ch2_hit = chan_summary(ch_faults.ch2, diag_mask_r) & ~ch_mask_r[FML_BIT_CH2];

  // pulse modes need pin timing held elsewhere; all modes act as level here
  assign irq_any = (|dev_unmasked) | ch1_hit | ch2_hit;

  // readback view of the latch, optionally hiding masked events
  assign latch_view = cfg.latched_readback_option ? dev_unmasked : latch_r;

  // read data selection; unmapped offsets read zero
  always_comb begin
    rd_mux = FML_RDATA_IDLE;
    case (req.addr)
      FML_OFS_DEV_MASK: begin
        rd_mux = dev_mask_r;
      end
      FML_OFS_CH_MASK: begin
        rd_mux = ch_mask_r;
      end
      FML_OFS_DIAG_MASK: begin
        rd_mux = diag_mask_r;
      end
      FML_OFS_LATCH: begin
        rd_mux = {latch_view, FML_RESERVED_ZERO};
      end
      default: begin
        rd_mux = FML_RDATA_IDLE;
      end
    endcase
  end

  // read data register, one cycle after the strobe, held until the next read
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_r <= FML_RDATA_IDLE;
      rdata_valid_r <= 1'b0;
    end else begin
      rdata_valid_r <= req.rd_en;
      if (req.rd_en) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // irq pin registered so the pin never glitches on mask writes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_active_r <= 1'b0;
      irq_out_r <= FML_IRQ_RST_LEVEL;
    end else begin
      irq_active_r <= irq_any;
      irq_out_r <= cfg.irq_output_polarity ? irq_any : ~irq_any;
    end
  end

  assign rdata = rdata_r;
  assign rdata_valid = rdata_valid_r;
  assign irq_out = irq_out_r;

  // checks on the block's own behaviour
  default clocking fml_cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  dev_mask_reset_a: assert property ($past(!rstn) |-> dev_mask_r == FML_RST_DEV_MASK)
    else $error("device mask not all ones after reset");

  ch_mask_reset_a: assert property ($past(!rstn) |-> ch_mask_r == FML_RST_CH_MASK)
    else $error("channel mask reset value wrong");

  diag_mask_reset_a: assert property ($past(!rstn) |-> diag_mask_r == FML_RST_DIAG_MASK)
    else $error("diagnostic mask not zero after reset");

  latch_reset_a: assert property ($past(!rstn) |-> latch_r == FML_RST_LATCH)
    else $error("latched events not zero after reset");

  asi_unmask_irq_a: assert property (
    latch_r[FML_EVT_ASI] && !dev_mask_r[FML_EVT_LSB+FML_EVT_ASI] |=> irq_active_r)
    else $error("unmasked clock error did not raise irq");

  pll_unmask_irq_a: assert property (
    latch_r[FML_EVT_PLL] && !dev_mask_r[FML_EVT_LSB+FML_EVT_PLL] |=> irq_active_r)
    else $error("unmasked pll lock did not raise irq");

  otemp_unmask_irq_a: assert property (
    latch_r[FML_EVT_OTEMP] && !dev_mask_r[FML_EVT_LSB+FML_EVT_OTEMP] |=> irq_active_r)
    else $error("unmasked over-temperature did not raise irq");

  ocurr_unmask_irq_a: assert property (
    latch_r[FML_EVT_OCURR] && !dev_mask_r[FML_EVT_LSB+FML_EVT_OCURR] |=> irq_active_r)
    else $error("unmasked over-current did not raise irq");

  ch1_unmask_irq_a: assert property (
    ((ch_faults.ch1 & ~diag_mask_r) != '0) && !ch_mask_r[FML_BIT_CH1] |=> irq_active_r)
    else $error("unmasked channel 1 fault did not raise irq");

  ch2_unmask_irq_a: assert property (
    ((ch_faults.ch2 & ~diag_mask_r) != '0) && !ch_mask_r[FML_BIT_CH2] |=> irq_active_r)
    else $error("unmasked channel 2 fault did not raise irq");

  all_masked_quiet_a: assert property (
    ((latch_r & ~dev_mask_r[FML_EVT_MSB:FML_EVT_LSB]) == '0)
    && (ch_mask_r[FML_BIT_CH1] || ((ch_faults.ch1 & ~diag_mask_r) == '0))
    && (ch_mask_r[FML_BIT_CH2] || ((ch_faults.ch2 & ~diag_mask_r) == '0))
    |=> !irq_active_r)
    else $error("irq asserted with every source masked");

  diag_type_block_a: assert property (
    ((ch_faults.ch1 | ch_faults.ch2) & ~diag_mask_r) == '0 && latch_r == '0
    |=> !irq_active_r)
    else $error("masked fault type raised irq");

  irq_polarity_a: assert property (
    $past(rstn) |-> irq_out_r == ($past(cfg.irq_output_polarity) ? irq_active_r : !irq_active_r))
    else $error("irq pin level disagrees with polarity");

  asi_read_clear_a: assert property (
    rd_latch && cfg.clear_on_read_option && !evt_rise[FML_EVT_ASI]
    |=> !latch_r[FML_EVT_ASI])
    else $error("clock error latch not cleared by read");

  pll_read_clear_a: assert property (
    rd_latch && !cfg.clear_on_read_option && !live_sync[FML_EVT_PLL]
    |=> !latch_r[FML_EVT_PLL])
    else $error("pll latch not cleared by read with live low");

  otemp_read_hold_a: assert property (
    rd_latch && !cfg.clear_on_read_option && live_sync[FML_EVT_OTEMP]
    |=> latch_r[FML_EVT_OTEMP])
    else $error("latch cleared while live status high");

  ocurr_rise_set_a: assert property (
    live_sync[FML_EVT_OCURR] && !live_prev_r[FML_EVT_OCURR] |=> latch_r[FML_EVT_OCURR])
    else $error("rising over-current not latched");

  live_capture_a: assert property (
    !cfg.clear_on_read_option && live_sync[FML_EVT_OTEMP] |=> latch_r[FML_EVT_OTEMP])
    else $error("live event not captured despite mask");

  rearm_only_rise_a: assert property (
    cfg.clear_on_read_option && rd_latch && live_sync[FML_EVT_PLL]
    && live_prev_r[FML_EVT_PLL] |=> !latch_r[FML_EVT_PLL])
    else $error("latch set again without a new rising edge");

  readback_masked_a: assert property (
    req.rd_en && reg_hit(req.addr, FML_OFS_LATCH) && cfg.latched_readback_option
    |=> rdata_r[FML_EVT_MSB:FML_EVT_LSB]
        == ($past(latch_r) & ~$past(dev_mask_r[FML_EVT_MSB:FML_EVT_LSB])))
    else $error("readback shows masked events");

  readback_all_a: assert property (
    req.rd_en && reg_hit(req.addr, FML_OFS_LATCH) && !cfg.latched_readback_option
    |=> rdata_r[FML_EVT_MSB:FML_EVT_LSB] == $past(latch_r))
    else $error("readback does not show all latched events");

  reserved_zero_a: assert property (
    req.rd_en && reg_hit(req.addr, FML_OFS_LATCH) |=> rdata_r[FML_EVT_LSB-1:0] == '0
    && rdata_valid_r)
    else $error("latched reserved bits not zero");

endmodule

// file: fml_host_model.sv
// host processor model: drives register strobes and takes read answers
`timescale 1ns/1ps
module fml_host_model
  import fml_pkg::*;
(
  input wire logic clk,
  output fml_req_t req,
  input wire logic [FML_DATA_W-1:0] rdata,
  input wire logic rdata_valid
);
  initial req = '0;

  // one write strobe, held through the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] dw;
    dw = d;
    // reserved bits of the device and channel masks always carry their reset values, whatever the caller asks
    if (a == FML_OFS_DEV_MASK) dw[3:0] = FML_RST_DEV_MASK[3:0];
    if (a == FML_OFS_CH_MASK) dw[5:0] = FML_RST_CH_MASK[5:0];
    @(posedge clk);
    #1 req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: dw};
    @(posedge clk);
    #1 req = '0;
  endtask

  // one read strobe; answer registered at the taking edge
  task automatic rd(input logic [7:0] a, output logic v, output logic [7:0] d);
    @(posedge clk);
    #1 req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    #1 req = '0;
    v = rdata_valid;
    d = rdata;
  endtask
endmodule

// file: fml_irq_mask_latch_tb.sv
// self-checking bench for the interrupt mask and latch block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module fml_irq_mask_latch_tb;
  import fml_pkg::*;
  logic clk;
  logic rstn;
  fml_req_t req;
  fml_dev_evt_t dev_evt_live;
  fml_ch_faults_t ch_faults;
  fml_cfg_t cfg;
  logic [FML_DATA_W-1:0] rdata;
  logic rdata_valid;
  logic irq_out;
  int n_mismatch = 0;
  int total_checks = 0;
  int i;

  fml_irq_mask_latch fml_irq_mask_latch_inst (.clk(clk), .rstn(rstn), .req(req),
    .dev_evt_live(dev_evt_live), .ch_faults(ch_faults), .cfg(cfg), .rdata(rdata),
    .rdata_valid(rdata_valid), .irq_out(irq_out));
  fml_host_model fml_host_model_inst (.clk(clk), .req(req), .rdata(rdata),
    .rdata_valid(rdata_valid));

  // 250 MHz
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // inputs always move 1 ns after an edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    fml_host_model_inst.wr(a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic v;
    logic [7:0] d;
    fml_host_model_inst.rd(a, v, d);
    `CHK("rdata_valid", 1'b1, v)
    `CHK("rdata", e, d)
  endtask

  // bounded wait for the pin to reach its active or idle level
  task automatic wait_irq(input logic act, input int n);
    logic ex;
    ex = act ? cfg.irq_output_polarity : ~cfg.irq_output_polarity;
    for (int k = 0; k < n && irq_out !== ex; k++) tick(1);
    `CHK("irq_out", ex, irq_out)
    if (irq_out !== ex) wrap_up();
  endtask

  initial begin
    rstn = 1'b0;
    dev_evt_live = '0;
    ch_faults = '0;
    cfg = '0;
    repeat (20) @(posedge clk);
    #1 rstn = 1'b1;
    // reset values, read-only latch, unmapped place
    wait_irq(1'b0, 4);
    rd_chk(FML_OFS_DEV_MASK, 8'hff);
    rd_chk(FML_OFS_CH_MASK, 8'h03);
    rd_chk(FML_OFS_DIAG_MASK, 8'h00);
    rd_chk(FML_OFS_LATCH, 8'h00);
    wr(FML_OFS_LATCH, 8'hff);
    rd_chk(FML_OFS_LATCH, 8'h00);
    rd_chk(8'h30, 8'h00);
    wr(FML_OFS_DIAG_MASK, 8'ha5);
    rd_chk(FML_OFS_DIAG_MASK, 8'ha5);
    wr(FML_OFS_DIAG_MASK, 8'h00);
    // each device event: latched while masked, gated by its mask, cleared by read
    for (i = 0; i < 4; i++) begin
      wr(FML_OFS_DEV_MASK, 8'hff);
      dev_evt_live = fml_dev_evt_t'(4'h8 >> i);
      tick(6);
      `CHK("irq_out", 1'b1, irq_out)
      rd_chk(FML_OFS_LATCH, 8'h80 >> i);
      wr(FML_OFS_DEV_MASK, ~(8'h80 >> i));
      wait_irq(1'b1, 8);
      dev_evt_live = '0;
      tick(4);
      rd_chk(FML_OFS_LATCH, 8'h80 >> i);
      rd_chk(FML_OFS_LATCH, 8'h00);
      wait_irq(1'b0, 4);
    end
    // polarity and clear options with the lock event held high
    wr(FML_OFS_DEV_MASK, 8'hbf);
    dev_evt_live = fml_dev_evt_t'(4'h4);
    wait_irq(1'b1, 8);
    cfg.irq_output_polarity = 1'b1;
    tick(2);
    `CHK("irq_out", 1'b1, irq_out)
    cfg.irq_output_polarity = 1'b0;
    tick(2);
    `CHK("irq_out", 1'b0, irq_out)
    rd_chk(FML_OFS_LATCH, 8'h40);
    rd_chk(FML_OFS_LATCH, 8'h40);
    cfg.clear_on_read_option = 1'b1;
    rd_chk(FML_OFS_LATCH, 8'h40);
    rd_chk(FML_OFS_LATCH, 8'h00);
    dev_evt_live = '0;
    tick(4);
    dev_evt_live = fml_dev_evt_t'(4'h4);
    tick(5);
    rd_chk(FML_OFS_LATCH, 8'h40);
    // masked events hidden when only unmasked ones are shown
    wr(FML_OFS_DEV_MASK, 8'hff);
    dev_evt_live = '0;
    tick(4);
    dev_evt_live = fml_dev_evt_t'(4'h4);
    tick(5);
    cfg.latched_readback_option = 1'b1;
    rd_chk(FML_OFS_LATCH, 8'h00);
    cfg = '0;
    dev_evt_live = '0;
    tick(4);
    wait_irq(1'b0, 4);
    // every diagnostic fault type on channel 1, then masked by its type bit
    for (i = 0; i < 8; i++) begin
      ch_faults.ch1 = 8'h01 << i;
      wait_irq(1'b1, 4);
      wr(FML_OFS_DIAG_MASK, 8'h01 << i);
      wait_irq(1'b0, 4);
    end
    // drop the channel 1 fault first, so each summary test starts from an idle pin
    ch_faults = '0;
    wr(FML_OFS_DIAG_MASK, 8'h00);
    wait_irq(1'b0, 4);
    // channel summary masks
    ch_faults = '{ch1: 8'h00, ch2: 8'h01};
    wait_irq(1'b1, 4);
    wr(FML_OFS_CH_MASK, 8'h43);
    wait_irq(1'b0, 4);
    ch_faults = '{ch1: 8'h01, ch2: 8'h00};
    wait_irq(1'b1, 4);
    wr(FML_OFS_CH_MASK, 8'h83);
    wait_irq(1'b0, 4);
    rd_chk(FML_OFS_CH_MASK, 8'h83);
    wrap_up();
  end
endmodule
